// ### pmc_pkg.sv
// Purpose: constants and types for the power mode clock controller
// Assumes: 8-bit register port, single 100 MHz system clock
// Notes: register addresses are the byte offsets of the port
package pmc_pkg;
    // register addresses
    localparam logic [7:0] PMC_POWER_CONTROL_REG_ADDR = 8'h87;
    localparam logic [7:0] PMC_PMR_ADDR = 8'hC4;
    localparam logic [7:0] PMC_STAT_ADDR = 8'hC5;
    localparam logic [7:0] PMC_TB_ADDR = 8'hC9;
    localparam logic [7:0] PMC_SYSTEM_CLOCK_SELECT_ADDR = 8'h8F;
    localparam logic [7:0] PMC_WAKE_SOURCE_MASK_ADDR = 8'h9F;
    // reset values and divider codes
    localparam logic [7:0] PMC_SYSTEM_CLOCK_SELECT_RST = 8'hC0;
    localparam logic [7:0] PMC_WAKE_SOURCE_MASK_RST = 8'hFF;
    localparam logic [1:0] PMC_CD_FULL = 2'h1;
    localparam logic [1:0] PMC_CD_RED = 2'h3;
    // field positions
    localparam int PMC_WAKE_DELAY_FIELD_LSB = 5;
    localparam int PMC_CLKSRC_LSB = 0;
    localparam int PMC_POWER_CONTROL_REG_IDLE = 0;
    localparam int PMC_POWER_CONTROL_REG_STOP = 1;
    localparam int PMC_POWER_CONTROL_REG_SLEEP = 2;
    localparam int PMC_POWER_CONTROL_REG_SMOD0 = 7;
    localparam int PMC_PMR_SWB = 5;
    localparam int PMC_PMR_CD_LSB = 6;
    localparam int PMC_STAT_HP = 6;
    localparam int PMC_STAT_LP = 5;
    localparam int PMC_STAT_TX = 1;
    localparam int PMC_STAT_RX = 0;
    // timed access keys and window
    localparam logic [7:0] PMC_TB_KEY1 = 8'hAA;
    localparam logic [7:0] PMC_TB_KEY2 = 8'h55;
    localparam logic [7:0] PMC_TB_CLOSE = 8'h00;
    localparam logic [8:0] PMC_TB_WIN = 9'h100;
    // reduced rate divides by 257: count 0..256
    localparam logic [8:0] PMC_DIV_TOP = 9'h100;
    // wake delay in oscillator cycles per code
    localparam logic [13:0] PMC_WAKE_DELAY_FIELD_TAB [8] = '{
        14'h0000, 14'h0080, 14'h0100, 14'h0200,
        14'h0400, 14'h0800, 14'h1000, 14'h2000};

    typedef enum logic [4:0] {
        PM_RUN = 5'h01,
        PM_IDLE = 5'h02,
        PM_STOP = 5'h04,
        PM_SLEEP = 5'h08,
        PM_WAKE = 5'h10
    } pmc_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pmc_bus_t;

    typedef struct packed {
        logic hp;
        logic lp;
        logic tx;
        logic rx;
    } pmc_act_t;

    typedef struct packed {
        pmc_mode_t mode;
        logic [7:0] ck_sel;
        logic [7:0] wk_mask;
        logic smod0;
        logic [1:0] cd;
        logic switchback_enable;
        logic pend_idle;
        logic pend_stop;
        logic pend_sleep;
        logic tb_key1;
        logic [8:0] tb_cnt;
        logic [8:0] div_cnt;
        logic [13:0] dly_cnt;
        logic [8:0] wreq_q;
        logic rxd_q;
        logic cpu_clk_en;
        logic periph_clk_en;
        logic internal_oscillator_en;
        logic regul_off;
        logic resume;
        logic [7:0] rd_data;
    } pmc_state_t;
endpackage : pmc_pkg

// ### pmc_ctrl.sv
// Purpose: clock source select, reduced-rate, idle, stop and sleep control
// Assumes: srst covers both the reset pin and the watchdog reset
// Notes: clock gating is given as enables; the gating cells sit outside
//
// Notes on behaviour
// - high-priority activity bit mirrors service in progress
// - low-priority activity bit mirrors service in progress
// - uart0 tx/rx activity bits, read-only
// - wake delay code sets oscillator cycle count
// - clock source field picks system clock, reset C0
// - wake mask per line except line 5, resets to FF
// - enabled wake edge restarts oscillator and clock
// - wake resumes cpu whether or not isr entered
// - both divider bits set divide cpu by 257
// - writing 01 restores full speed
// - enabled unblocked interrupt on any line but 5 with switchback ends reduced rate
// - uart start edge with rx enabled switches back
// - transmit buffer load switches back immediately
// - no automatic re-entry; resets force full speed
// - idle stops cpu clock, peripherals keep running
// - enabled interrupt ends idle, idle bit clears
// - stop halts all clocks, oscillator off cleanly
// - only pins and async flags leave stop
// - stop wake needs enable and mask bit
// - wake restarts cpu, stop bit self-clears
// - protected writes only inside 256-cycle key window
// - stop alone is stop; stop plus sleep is sleep
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
module pmc_ctrl
    import pmc_pkg::*;
#(
    // shortens the long wake delays in simulation
    parameter int unsigned WAKE_DLY_SHIFT = 0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // register port
    input wire pmc_bus_t bus,
    output logic [7:0] rd_data,
    // cpu core status
    input wire logic instr_done,
    input wire pmc_act_t act,
    // interrupt lines 0..8
    input wire logic [8:0] ext_int_n,
    input wire logic [8:0] periph_flag,
    input wire logic [8:0] int_en,
    input wire logic [8:0] int_blocked,
    // uart0 switchback sources
    input wire logic uart0_rxd,
    input wire logic uart0_rx_en,
    input wire logic uart0_tx_load,
    // clock control outputs
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic internal_oscillator_en,
    output logic regulator_off,
    output logic [1:0] clk_source,
    output logic smod0,
    output logic cpu_resume
);
    pmc_state_t s;
    pmc_state_t next_s;
    logic [8:0] line_req;
    logic [8:0] stop_req;
    logic [8:0] sb_req;
    logic [8:0] mask9;
    logic tb_open;
    logic red_run;
    logic stop_wake;
    logic idle_wake;
    logic switchback;

    // line 5 has no mask bit and never wakes from stop
    assign mask9 = {s.wk_mask[7:5], 1'b0, s.wk_mask[4:0]};
    assign tb_open = (s.tb_cnt != 9'h000);
    assign red_run = (s.mode == PM_RUN) && (s.cd == PMC_CD_RED);

    for (genvar i = 0; i < 9; i++) begin : g_line
        assign line_req[i] = ~ext_int_n[i] | periph_flag[i];
        assign stop_req[i] = line_req[i] & int_en[i] & mask9[i];
        assign sb_req[i] = line_req[i] & int_en[i] & ~int_blocked[i] & (i != 5);
    end

    // wake on rising edge even for level irqs
    assign stop_wake = |(stop_req & ~s.wreq_q);
    assign idle_wake = |(line_req & int_en);
    assign switchback = s.switchback_enable && (|sb_req || (s.rxd_q && !uart0_rxd && uart0_rx_en)
        || uart0_tx_load);

    always_comb begin
        next_s = s;
        next_s.resume = 1'b0;
        next_s.rd_data = 8'h00;
        next_s.wreq_q = stop_req;
        next_s.rxd_q = uart0_rxd;
        if (tb_open) begin
            next_s.tb_cnt = s.tb_cnt - 9'h001;
        end

        if (bus.wr) begin
            unique case (bus.addr)
                PMC_TB_ADDR: begin
                    next_s.tb_key1 = (bus.wdata == PMC_TB_KEY1);
                    if (s.tb_key1 && bus.wdata == PMC_TB_KEY2) begin
                        next_s.tb_cnt = PMC_TB_WIN;
                    end else if (bus.wdata == PMC_TB_CLOSE) begin
                        next_s.tb_cnt = 9'h000;
                    end
                end
                PMC_SYSTEM_CLOCK_SELECT_ADDR: begin
                    if (tb_open) begin
                        next_s.ck_sel = bus.wdata;
                    end
                end
                PMC_WAKE_SOURCE_MASK_ADDR: begin
                    if (tb_open) begin
                        next_s.wk_mask = bus.wdata;
                    end
                end
                PMC_POWER_CONTROL_REG_ADDR: begin
                    next_s.smod0 = bus.wdata[PMC_POWER_CONTROL_REG_SMOD0];
                    next_s.pend_idle = s.pend_idle | bus.wdata[PMC_POWER_CONTROL_REG_IDLE];
                    next_s.pend_stop = s.pend_stop | bus.wdata[PMC_POWER_CONTROL_REG_STOP];
                    next_s.pend_sleep = s.pend_sleep | bus.wdata[PMC_POWER_CONTROL_REG_SLEEP];
                end
                PMC_PMR_ADDR: begin
                    next_s.cd = bus.wdata[PMC_PMR_CD_LSB +: 2];
                    next_s.switchback_enable = bus.wdata[PMC_PMR_SWB];
                end
                default: begin
                end
            endcase
        end

        // switchback wins over a same-cycle write
        if (red_run && switchback) begin
            // stays full speed until software again
            next_s.cd = PMC_CD_FULL;
        end

        unique case (s.mode)
            PM_RUN: begin
                if (instr_done && s.pend_stop) begin
                    next_s.mode = s.pend_sleep ? PM_SLEEP : PM_STOP;
                    next_s.pend_stop = 1'b0;
                    next_s.pend_sleep = 1'b0;
                    next_s.pend_idle = 1'b0;
                end else if (instr_done && s.pend_idle) begin
                    next_s.mode = PM_IDLE;
                    next_s.pend_idle = 1'b0;
                    next_s.pend_sleep = 1'b0;
                end
            end
            PM_IDLE: begin
                if (idle_wake) begin
                    next_s.mode = PM_RUN;
                    next_s.resume = 1'b1;
                end
            end
            PM_STOP, PM_SLEEP: begin
                if (stop_wake) begin
                    // wake always restarts on the internal oscillator
                    next_s.ck_sel[PMC_CLKSRC_LSB +: 2] = 2'h0;
                    next_s.dly_cnt = PMC_WAKE_DELAY_FIELD_TAB[s.ck_sel[PMC_WAKE_DELAY_FIELD_LSB +: 3]]
                        >> WAKE_DLY_SHIFT;
                    if (next_s.dly_cnt == 14'h0000) begin
                        next_s.mode = PM_RUN;
                        next_s.resume = 1'b1;
                    end else begin
                        next_s.mode = PM_WAKE;
                    end
                end
            end
            PM_WAKE: begin
                next_s.dly_cnt = s.dly_cnt - 14'h0001;
                if (s.dly_cnt == 14'h0001) begin
                    next_s.mode = PM_RUN;
                    next_s.resume = 1'b1;
                end
            end
        endcase

        if (next_s.mode == PM_RUN && next_s.cd == PMC_CD_RED) begin
            next_s.div_cnt = (s.div_cnt == PMC_DIV_TOP) ? 9'h000 : s.div_cnt + 9'h001;
            next_s.cpu_clk_en = (s.div_cnt == PMC_DIV_TOP);
        end else begin
            next_s.div_cnt = 9'h000;
            next_s.cpu_clk_en = (next_s.mode == PM_RUN);
        end
        next_s.periph_clk_en = (next_s.mode == PM_RUN) || (next_s.mode == PM_IDLE);
        // oscillator drops on a registered edge, no runt pulse
        next_s.internal_oscillator_en = (next_s.mode != PM_STOP) && (next_s.mode != PM_SLEEP);
        next_s.regul_off = (next_s.mode == PM_SLEEP);

        if (bus.rd) begin
            unique case (bus.addr)
                PMC_POWER_CONTROL_REG_ADDR: next_s.rd_data[PMC_POWER_CONTROL_REG_SMOD0] = s.smod0;
                PMC_PMR_ADDR: next_s.rd_data = {s.cd, s.switchback_enable, 5'h00};
                PMC_STAT_ADDR: begin
                    next_s.rd_data[PMC_STAT_HP] = act.hp;
                    next_s.rd_data[PMC_STAT_LP] = act.lp;
                    next_s.rd_data[PMC_STAT_TX] = act.tx;
                    next_s.rd_data[PMC_STAT_RX] = act.rx;
                end
                PMC_TB_ADDR: next_s.rd_data[0] = tb_open;
                PMC_SYSTEM_CLOCK_SELECT_ADDR: next_s.rd_data = s.ck_sel & 8'hE3;
                PMC_WAKE_SOURCE_MASK_ADDR: next_s.rd_data = s.wk_mask;
                default: next_s.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s <= '0;
            s.mode <= PM_RUN;
            s.ck_sel <= PMC_SYSTEM_CLOCK_SELECT_RST;
            s.wk_mask <= PMC_WAKE_SOURCE_MASK_RST;
            s.cd <= PMC_CD_FULL;
            s.rxd_q <= 1'b1;
            s.cpu_clk_en <= 1'b1;
            s.periph_clk_en <= 1'b1;
            s.internal_oscillator_en <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data = s.rd_data;
    assign cpu_clk_en = s.cpu_clk_en;
    assign periph_clk_en = s.periph_clk_en;
    assign internal_oscillator_en = s.internal_oscillator_en;
    assign regulator_off = s.regul_off;
    assign clk_source = s.ck_sel[PMC_CLKSRC_LSB +: 2];
    assign smod0 = s.smod0;
    assign cpu_resume = s.resume;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    sequence s_rd_stat;
        bus.rd && bus.addr == PMC_STAT_ADDR;
    endsequence
    sequence s_tb_keys;
        bus.wr && bus.addr == PMC_TB_ADDR && bus.wdata == PMC_TB_KEY1
        ##1 bus.wr && bus.addr == PMC_TB_ADDR && bus.wdata == PMC_TB_KEY2;
    endsequence

    property p_hp_stat;
        s_rd_stat |=> rd_data[PMC_STAT_HP] == $past(act.hp);
    endproperty
    a_hp_stat: assert property (p_hp_stat) else $error("hp status mismatch");

    property p_rx_stat;
        s_rd_stat |=> rd_data[PMC_STAT_RX] == $past(act.rx)
            && rd_data[PMC_STAT_TX] == $past(act.tx);
    endproperty
    a_rx_stat: assert property (p_rx_stat) else $error("uart status mismatch");

    property p_tb_open;
        s_tb_keys |=> s.tb_cnt == PMC_TB_WIN;
    endproperty
    a_tb_open: assert property (p_tb_open) else $error("window not opened");

    // a close or a reload may cut the window short, so check one step at a time
    property p_tb_run;
        tb_open && !(bus.wr && bus.addr == PMC_TB_ADDR)
            |=> s.tb_cnt == $past(s.tb_cnt) - 9'h001;
    endproperty
    a_tb_run: assert property (p_tb_run) else $error("window count wrong");

    property p_ck_lock;
        bus.wr && bus.addr == PMC_SYSTEM_CLOCK_SELECT_ADDR && !tb_open && s.mode == PM_RUN
            |=> s.ck_sel == $past(s.ck_sel);
    endproperty
    a_ck_lock: assert property (p_ck_lock) else $error("locked write took");

    property p_rr_gap;
        (red_run && s.div_cnt == 9'h000) ##1 red_run [*8] |-> !cpu_clk_en;
    endproperty
    a_rr_gap: assert property (p_rr_gap) else $error("divider pulse early");

    property p_tx_sb;
        red_run && s.switchback_enable && uart0_tx_load |=> s.cd == PMC_CD_FULL ##1 cpu_clk_en;
    endproperty
    a_tx_sb: assert property (p_tx_sb) else $error("tx switchback missed");

    property p_stop_off;
        s.mode == PM_STOP |-> !internal_oscillator_en && !cpu_clk_en && !periph_clk_en && !regulator_off;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("clock live in stop");

    property p_late_entry;
        bus.wr && bus.addr == PMC_POWER_CONTROL_REG_ADDR && s.mode == PM_RUN && !instr_done
            |=> s.mode == PM_RUN;
    endproperty
    a_late_entry: assert property (p_late_entry) else $error("entered mid instruction");

    property p_stop_wake;
        (s.mode == PM_STOP) && stop_wake && s.ck_sel[7:5] == 3'h0
            |=> s.mode == PM_RUN && cpu_resume && internal_oscillator_en && clk_source == 2'h0;
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("stop wake failed");

    property p_idle_exit;
        s.mode == PM_IDLE && idle_wake |=> s.mode == PM_RUN && cpu_resume && cpu_clk_en;
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle exit failed");
endmodule : pmc_ctrl

// ### pmc_core_model.sv
// Purpose: cpu core stand-in that ends one instruction every three clocked cycles
// Assumes: the core only advances while the controller enables its clock
// Notes: no instruction ends while the cpu clock is gated
`timescale 1ns/1ns
module pmc_core_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // gated cpu clock enable
    input wire logic cpu_clk_en,
    // instruction end pulse
    output logic instr_done
);
    logic [1:0] phase;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            phase <= 2'h0;
            instr_done <= 1'b0;
        end else begin
            instr_done <= cpu_clk_en && (phase == 2'h2);
            if (cpu_clk_en) begin
                phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            end
        end
    end
endmodule : pmc_core_model

// ### power_mode_clock_controller_bench.sv
// Purpose: register-level bench for the power mode clock controller
// Assumes: wake delays shortened by WAKE_DLY_SHIFT
// Notes: every task starts and ends 1 ns after a rising edge
`timescale 1ns/1ns
module power_mode_clock_controller_bench;
    import pmc_pkg::*;
    localparam int SHIFT = 4;
    localparam int DLY = 256 >> SHIFT;
    localparam logic [7:0] ST_EXP [4] = '{8'h40, 8'h20, 8'h02, 8'h01};
    logic sys_clk, srst, instr_done, smod0;
    pmc_bus_t bus;
    logic [7:0] rd_data, d;
    pmc_act_t act;
    logic [8:0] ext_int_n, periph_flag, int_en, int_blocked;
    logic uart0_rxd, uart0_rx_en, uart0_tx_load;
    logic cpu_clk_en, periph_clk_en, internal_oscillator_en, regulator_off, cpu_resume;
    logic [1:0] clk_source;
    int err_count, total_checks, n, k;

    pmc_ctrl #(.WAKE_DLY_SHIFT(SHIFT)) DUT (.sys_clk(sys_clk), .srst(srst), .bus(bus),
        .rd_data(rd_data), .instr_done(instr_done), .act(act), .ext_int_n(ext_int_n),
        .periph_flag(periph_flag), .int_en(int_en), .int_blocked(int_blocked),
        .uart0_rxd(uart0_rxd), .uart0_rx_en(uart0_rx_en), .uart0_tx_load(uart0_tx_load),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .internal_oscillator_en(internal_oscillator_en),
        .regulator_off(regulator_off), .clk_source(clk_source), .smod0(smod0),
        .cpu_resume(cpu_resume));
    pmc_core_model core (.sys_clk(sys_clk), .srst(srst), .cpu_clk_en(cpu_clk_en),
        .instr_done(instr_done));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask : step

    // one idle edge first, so the release and the next request never share a time step
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        step(1);
        bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        step(1);
        bus <= '0;
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        step(1);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        step(1);
        d = rd_data;
        bus <= '0;
        chk(d, exp);
    endtask : rchk

    // keys back to back, as the key sequence check expects
    task automatic open_win;
        step(1);
        bus <= '{addr: PMC_TB_ADDR, wdata: PMC_TB_KEY1, wr: 1'b1, rd: 1'b0};
        step(1);
        bus <= '{addr: PMC_TB_ADDR, wdata: PMC_TB_KEY2, wr: 1'b1, rd: 1'b0};
        step(1);
        bus <= '0;
    endtask : open_win

    function automatic logic pick(input int sel);
        case (sel)
            0: return cpu_clk_en;
            1: return cpu_resume;
            default: return internal_oscillator_en;
        endcase
    endfunction : pick

    // bounded wait; a hang ends the run
    task automatic wait_on(input int sel, input logic v, output int cnt);
        cnt = 0;
        while (pick(sel) !== v) begin
            if (cnt == 600) begin
                err_count++;
                $display("mismatch at %0t: wait ran out", $time);
                results();
            end
            cnt++;
            step(1);
        end
    endtask : wait_on

    initial begin
        srst = 1'b1;
        bus = '0;
        act = '0;
        ext_int_n = 9'h1FF;
        periph_flag = 9'h000;
        int_en = 9'h1FF;
        int_blocked = 9'h000;
        uart0_rxd = 1'b1;
        uart0_rx_en = 1'b0;
        uart0_tx_load = 1'b0;
        err_count = 0;
        total_checks = 0;
        step(4);
        srst <= 1'b0;
        step(1);
        chk({3'h0, cpu_clk_en, internal_oscillator_en, regulator_off, clk_source}, 8'h18);
        rchk(PMC_SYSTEM_CLOCK_SELECT_ADDR, 8'hC0);
        rchk(PMC_WAKE_SOURCE_MASK_ADDR, 8'hFF);
        rchk(PMC_PMR_ADDR, 8'h40);
        for (k = 0; k < 4; k++) begin
            act <= pmc_act_t'(4'h8 >> k);
            step(1);
            rchk(PMC_STAT_ADDR, ST_EXP[k]);
        end
        act <= '0;
        wr(PMC_STAT_ADDR, 8'hFF);
        rchk(PMC_STAT_ADDR, 8'h00);
        wr(PMC_SYSTEM_CLOCK_SELECT_ADDR, 8'h01);
        rchk(PMC_SYSTEM_CLOCK_SELECT_ADDR, 8'hC0);
        open_win;
        for (k = 0; k < 4; k++) begin
            wr(PMC_SYSTEM_CLOCK_SELECT_ADDR, 8'(k));
            chk({6'h00, clk_source}, 8'(k));
        end
        wr(PMC_SYSTEM_CLOCK_SELECT_ADDR, 8'hFF);
        rchk(PMC_SYSTEM_CLOCK_SELECT_ADDR, 8'hE3);
        step(260);
        wr(PMC_SYSTEM_CLOCK_SELECT_ADDR, 8'h00);
        rchk(PMC_SYSTEM_CLOCK_SELECT_ADDR, 8'hE3);
        open_win;
        wr(PMC_TB_ADDR, PMC_TB_CLOSE);
        wr(PMC_SYSTEM_CLOCK_SELECT_ADDR, 8'h00);
        rchk(PMC_SYSTEM_CLOCK_SELECT_ADDR, 8'hE3);
        // one enabled cycle in every 257
        wr(PMC_PMR_ADDR, 8'hC0);
        n = 0;
        repeat (514) begin
            step(1);
            if (cpu_clk_en === 1'b1) n++;
        end
        chk(8'(n), 8'h02);
        wr(PMC_PMR_ADDR, 8'h40);
        step(2);
        n = 0;
        repeat (8) begin
            step(1);
            if (cpu_clk_en === 1'b1) n++;
        end
        chk(8'(n), 8'h08);
        // blocked line and disabled receiver must not switch back
        wr(PMC_PMR_ADDR, 8'hE0);
        int_blocked <= 9'h008;
        ext_int_n <= 9'h1F7;
        uart0_rxd <= 1'b0;
        step(4);
        rchk(PMC_PMR_ADDR, 8'hE0);
        ext_int_n <= 9'h1FF;
        uart0_rxd <= 1'b1;
        uart0_rx_en <= 1'b1;
        step(1);
        int_blocked <= 9'h000;
        for (k = 0; k < 3; k++) begin
            step(1);
            case (k)
                0: ext_int_n <= 9'h1F7;
                1: uart0_rxd <= 1'b0;
                default: uart0_tx_load <= 1'b1;
            endcase
            step(1);
            uart0_tx_load <= 1'b0;
            ext_int_n <= 9'h1FF;
            uart0_rxd <= 1'b1;
            step(2);
            chk({7'h00, cpu_clk_en}, 8'h01);
            rchk(PMC_PMR_ADDR, 8'h60);
            wr(PMC_PMR_ADDR, 8'hE0);
        end
        srst <= 1'b1;
        step(1);
        srst <= 1'b0;
        step(1);
        rchk(PMC_PMR_ADDR, 8'h40);
        wr(PMC_POWER_CONTROL_REG_ADDR, 8'h01);
        wait_on(0, 1'b0, n);
        chk({6'h00, periph_clk_en, internal_oscillator_en}, 8'h03);
        ext_int_n <= 9'h1FE;
        wait_on(1, 1'b1, n);
        chk(8'(n), 8'h01);
        chk({7'h00, cpu_clk_en}, 8'h01);
        ext_int_n <= 9'h1FF;
        // stop wakes on lines 1 and 2 only; crystal chosen to see the forced return
        open_win;
        wr(PMC_WAKE_SOURCE_MASK_ADDR, 8'h06);
        wr(PMC_SYSTEM_CLOCK_SELECT_ADDR, 8'h41);
        wr(PMC_TB_ADDR, PMC_TB_CLOSE);
        rchk(PMC_WAKE_SOURCE_MASK_ADDR, 8'h06);
        wr(PMC_POWER_CONTROL_REG_ADDR, 8'h02);
        wait_on(2, 1'b0, n);
        chk({5'h00, cpu_clk_en, periph_clk_en, regulator_off}, 8'h00);
        ext_int_n <= 9'h1FE;
        periph_flag <= 9'h020;
        step(20);
        chk({7'h00, internal_oscillator_en}, 8'h00);
        ext_int_n <= 9'h1FC;
        wait_on(1, 1'b1, n);
        chk(8'(n >= DLY && n <= DLY + 3), 8'h01);
        chk({6'h00, clk_source}, 8'h00);
        ext_int_n <= 9'h1FF;
        periph_flag <= 9'h000;
        step(2);
        wr(PMC_POWER_CONTROL_REG_ADDR, 8'h06);
        wait_on(2, 1'b0, n);
        chk({7'h00, regulator_off}, 8'h01);
        periph_flag <= 9'h004;
        wait_on(1, 1'b1, n);
        chk({6'h00, regulator_off, internal_oscillator_en}, 8'h01);
        results();
    end
endmodule : power_mode_clock_controller_bench
